/* pkg/nmu_pkg.sv */
// Constants, encodings and register map of the normalize and multiply unit.
// *****************************************************************************
// Overview of operation
// - Normalize shifts sum and extension left until sum bits 0 and 1 differ or the count reaches zero.
// - Signed normalize copies sum bit 0 into the link before shifting.
// - Each normalize shift: extension 0 to sum 17, sum 0 lost, link to extension 17.
// - Final shift count is the negated count field plus shifts done; setup OR and load ops read it.
// - Normalize start loads shift count with two's complement of instruction bits 12-17.
// - After a normalize, interrupts are held off for two cycles.
// - Every normalize shift increments the shift count by one.
// - Multiply takes multiplier from sum, multiplicand from next memory word.
// - Step count comes from bits 12-17; fewer steps scale the product.
// - Unsigned prep: sum to extension, clear sum, load count, fetch operand.
// - Multiply arithmetic is unsigned and ends when the count reaches zero.
// - Signed prep sets sign-differs when link and sum bit 0 differ, clears link.
// - Signed prep moves multiplier to extension, complemented if negative.
// - Signed result carries product sign in sum bits 0 and 1.
// - Signed result with sign-differs set complements the extension register.
// - Each step adds operand when multiplier low bit is one, then shifts right.
// - Each right shift loses the low bit and increments the count once.
// - Bits 9-11 select op: 001 multiply, 100 normalize; bits 12-17 count.
// - Instruction bit 4 copies sum bit 0 into the link; multiply ops ignore it.
// *****************************************************************************
package nmu_pkg;
    localparam int unsigned WORD_W = 18;
    localparam int unsigned CNT_W  = 6;
    // Register byte offsets.
    localparam logic [7:0] OFF_INSTR  = 8'h00;
    localparam logic [7:0] OFF_SUM    = 8'h04;
    localparam logic [7:0] OFF_EXT    = 8'h08;
    localparam logic [7:0] OFF_LINK   = 8'h0C;
    localparam logic [7:0] OFF_COUNT  = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_OPND   = 8'h18;
    // Status field positions.
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_SD   = 1;
    localparam int unsigned ST_HOLD = 2;
    // Operation codes in instruction bits 9-11 (vector bits 8:6).
    localparam logic [2:0] OP_SETUP = 3'h0;
    localparam logic [2:0] OP_MUL   = 3'h1;
    localparam logic [2:0] OP_LEFT_JUSTIFY_OP  = 3'h4;
    // Interrupt hold-off length after a normalize, in cycles.
    localparam logic [1:0] HOLD_CYCLES = 2'h2;
    // Reset values.
    localparam logic [17:0] RST_WORD = 18'h00000;
    localparam logic [5:0]  RST_CNT  = 6'h00;
    typedef enum logic [2:0] {
        NMU_IDLE  = 3'h0,
        NMU_PREP  = 3'h1,
        NMU_FETCH = 3'h3,
        NMU_STEP  = 3'h2,
        NMU_FIN   = 3'h6
    } nmu_state_t;
endpackage

/* rtl/nmu_mul_step.sv */
// One add-and-shift-right step of the unsigned multiply.
`timescale 1ns/10ps
module nmu_mul_step #(
    parameter int unsigned W = 18
) (
    input  wire logic [W-1:0] sum_i,
    input  wire logic [W-1:0] ext_i,
    input  wire logic [W-1:0] opnd_i,
    output logic      [W-1:0] sum_o,
    output logic      [W-1:0] ext_o
);
    logic [W:0] total;

    // Add the operand only when the multiplier low bit is one, then shift. The carry
    // re-enters at the top so no product bit is lost; the low bit falls off.
    always_comb begin
        total = {1'b0, sum_i} + {1'b0, (ext_i[0] ? opnd_i : {W{1'b0}})};
        sum_o = total[W:1];
        ext_o = {total[0], ext_i[W-1:1]};
    end
endmodule // nmu_mul_step

/* rtl/nmu_unit.sv */
// Normalize and multiply datapath with its classic Wishbone register slave.
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module nmu_unit (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             mem_req_o,
    input  wire logic        mem_ack_i,
    input  wire logic [17:0] mem_data_i,
    output logic             busy_o,
    output logic             int_holdoff_o
);
    // *************************************************************************
    // State
    // *************************************************************************
    typedef struct packed {
        nmu_pkg::nmu_state_t fsm;
        logic [17:0] sum;
        logic [17:0] ext;
        logic        link;
        logic [5:0]  cnt;
        logic [17:0] opnd;
        logic [17:0] instr;
        logic        sd;
        logic        busy;
        logic [1:0]  hold_cnt;
        logic        hold;
        logic        ack;
        logic [31:0] rdata;
        logic        mem_req;
    } nmu_regs_t;

    nmu_regs_t st;
    nmu_regs_t next_st;

    logic [17:0] step_sum;
    logic [17:0] step_ext;
    logic [17:0] wmask;
    logic [2:0]  op;
    logic        is_signed_left_justify_op;
    logic        is_signed_mul;
    logic [5:0]  cnt_inc;
    logic        bus_req;

    // Instruction fields: document bit k sits at vector bit 17-k.
    assign op             = st.instr[8:6];
    assign is_signed_left_justify_op = st.instr[13];
    assign is_signed_mul  = st.instr[11];
    assign cnt_inc        = 6'(st.cnt + 6'h01);
    assign bus_req        = wb_cyc_i & wb_stb_i & ~st.ack;
    assign wmask          = {{2{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    nmu_mul_step #(
        .W (18)
    ) u_nmu_mul_step (
        .sum_i  (st.sum),
        .ext_i  (st.ext),
        .opnd_i (st.opnd),
        .sum_o  (step_sum),
        .ext_o  (step_ext)
    );

    // *************************************************************************
    // Next-state logic
    // *************************************************************************
    // One process holds the bus slave and the sequencer so that every register
    // has exactly one assignment path; bus writes lose to a running operation.
    always_comb begin
        next_st         = st;
        next_st.ack     = bus_req;
        next_st.rdata   = 32'h00000000;

        // Hold-off counter runs down after a normalize ends.
        if (st.hold_cnt != 2'h0) begin
            next_st.hold_cnt = 2'(st.hold_cnt - 2'h1);
        end
        next_st.hold = (next_st.hold_cnt != 2'h0);

        // Register reads answer one cycle after the request.
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                nmu_pkg::OFF_INSTR:  next_st.rdata = {14'h0000, st.instr};
                nmu_pkg::OFF_SUM:    next_st.rdata = {14'h0000, st.sum};
                nmu_pkg::OFF_EXT:    next_st.rdata = {14'h0000, st.ext};
                nmu_pkg::OFF_LINK:   next_st.rdata = {31'h00000000, st.link};
                nmu_pkg::OFF_COUNT:  next_st.rdata = {26'h0000000, st.cnt};
                nmu_pkg::OFF_STATUS: next_st.rdata = {29'h00000000, st.hold, st.sd, st.busy};
                nmu_pkg::OFF_OPND:   next_st.rdata = {14'h0000, st.opnd};
                default:             next_st.rdata = 32'h00000000;
            endcase
        end

        // Register writes take effect only while idle.
        if (bus_req && wb_we_i && st.fsm == nmu_pkg::NMU_IDLE) begin
            case (wb_adr_i)
                nmu_pkg::OFF_INSTR: begin
                    next_st.instr = (st.instr & ~wmask) | (wb_dat_i[17:0] & wmask);
                    next_st.fsm   = nmu_pkg::NMU_PREP;
                    next_st.busy  = 1'b1;
                end
                nmu_pkg::OFF_SUM: begin
                    next_st.sum = (st.sum & ~wmask) | (wb_dat_i[17:0] & wmask);
                end
                nmu_pkg::OFF_EXT: begin
                    next_st.ext = (st.ext & ~wmask) | (wb_dat_i[17:0] & wmask);
                end
                nmu_pkg::OFF_LINK: begin
                    if (wb_sel_i[0]) begin
                        next_st.link = wb_dat_i[0];
                    end
                end
                default: begin
                    next_st.busy = st.busy;
                end
            endcase
        end

        case (st.fsm)
            nmu_pkg::NMU_IDLE: begin
                next_st.mem_req = 1'b0;
            end
            // Preparatory phase: decode and set up the registers.
            nmu_pkg::NMU_PREP: begin
                if (op == nmu_pkg::OP_LEFT_JUSTIFY_OP) begin
                    next_st.cnt = 6'(~st.instr[5:0] + 6'h01);
                    if (is_signed_left_justify_op) begin
                        next_st.link = st.sum[17];
                    end
                    next_st.fsm = nmu_pkg::NMU_STEP;
                end else if (op == nmu_pkg::OP_MUL) begin
                    // Software is trusted to have cleared the link here.
                    next_st.cnt = 6'(~st.instr[5:0] + 6'h01);
                    next_st.sum = nmu_pkg::RST_WORD;
                    next_st.ext = st.sum;
                    next_st.sd  = 1'b0;
                    if (is_signed_mul) begin
                        // Link carries the operand sign stored by software.
                        next_st.sd   = st.link ^ st.sum[17];
                        next_st.link = 1'b0;
                        if (st.sum[17]) begin
                            next_st.ext = ~st.sum;
                        end
                    end
                    next_st.mem_req = 1'b1;
                    next_st.fsm     = nmu_pkg::NMU_FETCH;
                end else begin
                    // Setup: clears first, then the OR transfers.
                    next_st.sum = st.instr[9] ? nmu_pkg::RST_WORD : st.sum;
                    next_st.ext = st.instr[12] ? nmu_pkg::RST_WORD : st.ext;
                    if (st.instr[13]) begin
                        next_st.link = st.sum[17];
                    end
                    if (st.instr[0]) begin
                        next_st.sum = next_st.sum | {12'h000, st.cnt};
                    end
                    if (st.instr[1]) begin
                        next_st.sum = next_st.sum | next_st.ext;
                    end
                    if (st.instr[2]) begin
                        next_st.ext = ~next_st.ext;
                    end
                    next_st.busy = 1'b0;
                    next_st.fsm  = nmu_pkg::NMU_IDLE;
                end
            end
            // Memory cycle: the request holds until the partner answers.
            nmu_pkg::NMU_FETCH: begin
                if (mem_ack_i) begin
                    next_st.opnd    = mem_data_i;
                    next_st.mem_req = 1'b0;
                    next_st.fsm     = nmu_pkg::NMU_STEP;
                end
            end
            nmu_pkg::NMU_STEP: begin
                if (op == nmu_pkg::OP_LEFT_JUSTIFY_OP) begin
                    if (st.sum[17] != st.sum[16]) begin
                        next_st.fsm = nmu_pkg::NMU_FIN;
                    end else begin
                        next_st.sum = {st.sum[16:0], st.ext[17]};
                        next_st.ext = {st.ext[16:0], st.link};
                        next_st.cnt = cnt_inc;
                        if (cnt_inc == 6'h00) begin
                            next_st.fsm = nmu_pkg::NMU_FIN;
                        end
                    end
                end else begin
                    next_st.sum = step_sum;
                    next_st.ext = step_ext;
                    next_st.cnt = cnt_inc;
                    if (cnt_inc == 6'h00) begin
                        next_st.fsm = nmu_pkg::NMU_FIN;
                    end
                end
            end
            // Completion: sign fix-up for signed multiply, hold-off for normalize.
            nmu_pkg::NMU_FIN: begin
                if (op == nmu_pkg::OP_LEFT_JUSTIFY_OP) begin
                    next_st.hold_cnt = nmu_pkg::HOLD_CYCLES;
                    next_st.hold     = 1'b1;
                end else if (is_signed_mul) begin
                    next_st.sum[17] = st.sd;
                    next_st.sum[16] = st.sd;
                    if (st.sd) begin
                        next_st.ext = ~st.ext;
                    end
                end
                next_st.busy = 1'b0;
                next_st.fsm  = nmu_pkg::NMU_IDLE;
            end
            default: begin
                next_st.busy = 1'b0;
                next_st.fsm  = nmu_pkg::NMU_IDLE;
            end
        endcase
    end

    // *************************************************************************
    // State register
    // *************************************************************************
    // Asynchronous reset loads constants only.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st          <= '0;
            st.fsm      <= nmu_pkg::NMU_IDLE;
            st.sum      <= nmu_pkg::RST_WORD;
            st.ext      <= nmu_pkg::RST_WORD;
            st.opnd     <= nmu_pkg::RST_WORD;
            st.instr    <= nmu_pkg::RST_WORD;
            st.cnt      <= nmu_pkg::RST_CNT;
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o      = st.rdata;
    assign wb_ack_o      = st.ack;
    assign mem_req_o     = st.mem_req;
    assign busy_o        = st.busy;
    assign int_holdoff_o = st.hold;

    // *************************************************************************
    // Assertions
    // *************************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_left_justify_op_done;
        st.fsm == nmu_pkg::NMU_FIN && op == nmu_pkg::OP_LEFT_JUSTIFY_OP;
    endsequence

    sequence s_hold_two;
        int_holdoff_o [*2] ##1 !int_holdoff_o;
    endsequence

    a_left_justify_op_stop_cond: assert property (
        (st.fsm == nmu_pkg::NMU_STEP && op == nmu_pkg::OP_LEFT_JUSTIFY_OP && st.sum[17] != st.sum[16])
        |=> st.fsm == nmu_pkg::NMU_FIN && $stable(st.cnt))
        else $error("normalize did not stop on differing top bits");

    a_left_justify_op_shift_in: assert property (
        (st.fsm == nmu_pkg::NMU_STEP && op == nmu_pkg::OP_LEFT_JUSTIFY_OP && st.sum[17] == st.sum[16])
        |=> st.sum[0] == $past(st.ext[17]) && st.ext[0] == $past(st.link)
            && st.cnt == 6'($past(st.cnt) + 6'h01))
        else $error("normalize shift moved wrong bits");

    a_left_justify_op_sign_link: assert property (
        (st.fsm == nmu_pkg::NMU_PREP && op == nmu_pkg::OP_LEFT_JUSTIFY_OP && is_signed_left_justify_op)
        |=> st.link == $past(st.sum[17]))
        else $error("signed normalize did not copy sign to link");

    a_count_load: assert property (
        (st.fsm == nmu_pkg::NMU_PREP && (op == nmu_pkg::OP_LEFT_JUSTIFY_OP || op == nmu_pkg::OP_MUL))
        |=> 6'(st.cnt + $past(st.instr[5:0])) == 6'h00)
        else $error("shift count not loaded with negated field");

    a_hold_window: assert property (s_left_justify_op_done |=> s_hold_two)
        else $error("interrupt hold-off not two cycles");

    a_mul_prep: assert property (
        (st.fsm == nmu_pkg::NMU_PREP && op == nmu_pkg::OP_MUL && !is_signed_mul)
        |=> st.sum == 18'h00000 && st.ext == $past(st.sum) && mem_req_o)
        else $error("unsigned multiply prep wrong");

    a_mul_sign_diff: assert property (
        (st.fsm == nmu_pkg::NMU_PREP && op == nmu_pkg::OP_MUL && is_signed_mul)
        |=> st.sd == ($past(st.link) ^ $past(st.sum[17])) && !st.link)
        else $error("sign-differs flag or link wrong");

    a_mul_step: assert property (
        (st.fsm == nmu_pkg::NMU_STEP && op == nmu_pkg::OP_MUL && !st.ext[0])
        |=> st.sum == ($past(st.sum) >> 1) && st.ext[16:0] == $past(st.ext[17:1]))
        else $error("multiply step with zero bit changed sum");

    a_mul_end: assert property (
        (st.fsm == nmu_pkg::NMU_STEP && op == nmu_pkg::OP_MUL && st.cnt == 6'h3F)
        |=> st.fsm == nmu_pkg::NMU_FIN ##1 st.fsm == nmu_pkg::NMU_IDLE && !busy_o)
        else $error("multiply did not end at zero count");

    a_signed_result: assert property (
        (st.fsm == nmu_pkg::NMU_FIN && op == nmu_pkg::OP_MUL && is_signed_mul)
        |=> st.sum[17] == st.sd && st.sum[16] == st.sd
            && st.ext == ($past(st.sd) ? ~$past(st.ext) : $past(st.ext)))
        else $error("signed product sign fix-up wrong");

    // Count wrap, setup link copy, fetch wait and the adding step, which tests reach least often.
    a_left_justify_op_wrap: assert property (
        (st.fsm == nmu_pkg::NMU_STEP && op == nmu_pkg::OP_LEFT_JUSTIFY_OP && st.sum[17] == st.sum[16] && st.cnt == 6'h3F)
        |=> st.fsm == nmu_pkg::NMU_FIN && st.cnt == 6'h00)
        else $error("normalize count wrapped past zero");

    a_setup_link: assert property (
        (st.fsm == nmu_pkg::NMU_PREP && op == nmu_pkg::OP_SETUP && st.instr[13])
        |=> st.link == $past(st.sum[17]))
        else $error("setup did not copy sum sign to link");

    a_fetch_wait: assert property (
        (st.fsm == nmu_pkg::NMU_FETCH && !mem_ack_i)
        |=> st.fsm == nmu_pkg::NMU_FETCH && mem_req_o)
        else $error("operand fetch request dropped early");

    a_mul_add: assert property (
        (st.fsm == nmu_pkg::NMU_STEP && op == nmu_pkg::OP_MUL && st.ext[0])
        |=> {st.sum, st.ext[17]} == 19'({1'b0, $past(st.sum)} + {1'b0, $past(st.opnd)}))
        else $error("multiply step with one bit did not add operand");

    a_bus_ack: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a single cycle");
endmodule // nmu_unit

/* verification/nmu_mem_model.sv */
// Memory responder that hands the multiplicand word to the unit's fetch port.
`timescale 1ns/10ps
module nmu_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        mem_req_i,
    input  wire logic [17:0] word_i,
    input  wire logic [3:0]  delay_i,
    output logic             mem_ack_o,
    output logic [17:0]      mem_data_o
);
    // ********************
    // Fetch responder
    // ********************
    logic [3:0] wait_cnt;

    // Answer after delay_i waiting cycles, for one cycle only.
    // Outside the answer cycle the data lines toggle, so a stale word is never mistaken for a fresh one.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_ack_o  <= 1'b0;
            mem_data_o <= 18'h00000;
            wait_cnt   <= 4'h0;
        end else if (mem_req_i && !mem_ack_o && wait_cnt >= delay_i) begin
            mem_ack_o  <= 1'b1;
            mem_data_o <= word_i;
            wait_cnt   <= 4'h0;
        end else begin
            mem_ack_o  <= 1'b0;
            mem_data_o <= ~mem_data_o;
            wait_cnt   <= (mem_req_i && !mem_ack_o) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // nmu_mem_model

/* verification/nmu_unit_tb.sv */
// Self-checking bench for the normalize and multiply unit.
`timescale 1ns/10ps
module nmu_unit_tb;
    logic        core_clk_i;
    logic        rst_i;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        mem_req;
    logic        mem_ack;
    logic [17:0] mem_data;
    logic [17:0] mem_word;
    logic [3:0]  mem_delay;
    logic        busy;
    logic        holdoff;
    int          fails;
    int          compares;

    nmu_unit u_nmu_unit (.core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .mem_req_o(mem_req), .mem_ack_i(mem_ack), .mem_data_i(mem_data),
        .busy_o(busy), .int_holdoff_o(holdoff));

    nmu_mem_model u_nmu_mem_model (.clk_i(core_clk_i), .rst_i(rst_i), .mem_req_i(mem_req),
        .word_i(mem_word), .delay_i(mem_delay), .mem_ack_o(mem_ack), .mem_data_o(mem_data));

    // Free-running 250 MHz clock.
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // ********************
    // Bus and check helpers
    // ********************
    task automatic final_report;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One classic cycle; the request stands until ack is sampled high, so answers within 20 cycles are safe.
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge core_clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_sel  <= 4'hF;
        wb_adr  <= adr;
        wb_wdat <= wd;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1) begin
            fails++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        wb_xfer(1'b1, adr, wd, d);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_xfer(1'b0, adr, 32'h00000000, d);
        check(d, exp);
    endtask

    // Start an instruction, optionally poke it while busy, wait for the end and count hold-off cycles.
    task automatic run_op(input logic [17:0] instr, input logic poke, output int hold);
        int n;
        wr(nmu_pkg::OFF_INSTR, {14'h0000, instr});
        if (poke) begin
            wr(nmu_pkg::OFF_SUM, 32'h00015555);
            wr(nmu_pkg::OFF_INSTR, 32'h00034200);
        end
        hold = 0;
        for (n = 0; n < 600; n++) begin
            @(posedge core_clk_i);
            if (holdoff === 1'b1) hold++;
            if (busy === 1'b0) break;
        end
        repeat (4) begin
            @(posedge core_clk_i);
            if (holdoff === 1'b1) hold++;
        end
        if (n >= 600) begin
            fails++;
            final_report();
        end
    endtask

    task automatic do_left_justify_op(input logic [17:0] s, e, input logic l, input logic [17:0] instr,
                           input logic [17:0] es, ee, input logic el, input logic [5:0] ec, input logic poke);
        int hold;
        wr(nmu_pkg::OFF_SUM, {14'h0000, s});
        wr(nmu_pkg::OFF_EXT, {14'h0000, e});
        wr(nmu_pkg::OFF_LINK, {31'h00000000, l});
        run_op(instr, poke, hold);
        check(32'(hold), 32'h00000002);
        rd_chk(nmu_pkg::OFF_SUM, {14'h0000, es});
        rd_chk(nmu_pkg::OFF_EXT, {14'h0000, ee});
        rd_chk(nmu_pkg::OFF_LINK, {31'h00000000, el});
        rd_chk(nmu_pkg::OFF_COUNT, {26'h0000000, ec});
        run_op(18'h34201, 1'b0, hold);
        rd_chk(nmu_pkg::OFF_SUM, {26'h0000000, ec});
    endtask

    task automatic do_mul(input logic [17:0] mpy, input logic l, input logic [17:0] mcand, instr, es, ee,
                          input logic esd, input logic [3:0] dly);
        int hold;
        mem_word  <= mcand;
        mem_delay <= dly;
        wr(nmu_pkg::OFF_SUM, {14'h0000, mpy});
        wr(nmu_pkg::OFF_LINK, {31'h00000000, l});
        run_op(instr, 1'b0, hold);
        check(32'(hold), 32'h00000000);
        rd_chk(nmu_pkg::OFF_SUM, {14'h0000, es});
        rd_chk(nmu_pkg::OFF_EXT, {14'h0000, ee});
        rd_chk(nmu_pkg::OFF_OPND, {14'h0000, mcand});
        rd_chk(nmu_pkg::OFF_COUNT, 32'h00000000);
        rd_chk(nmu_pkg::OFF_LINK, 32'h00000000);
        rd_chk(nmu_pkg::OFF_STATUS, {29'h00000000, 1'b0, esd, 1'b0});
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset;
        check({29'h00000000, busy, holdoff, mem_req}, 32'h00000000);
        rd_chk(nmu_pkg::OFF_SUM, {14'h0000, nmu_pkg::RST_WORD});
        rd_chk(nmu_pkg::OFF_EXT, {14'h0000, nmu_pkg::RST_WORD});
        rd_chk(nmu_pkg::OFF_COUNT, {26'h0000000, nmu_pkg::RST_CNT});
        rd_chk(nmu_pkg::OFF_STATUS, 32'h00000000);
        wr(8'h40, 32'h0003FFFF);
        rd_chk(8'h40, 32'h00000000);
    endtask

    // Long shift with pokes while busy, signed shift of ones, count wrap, already normalized.
    task automatic t_normalize;
        do_left_justify_op(18'h00000, 18'h00003, 1'b0, 18'h34124, 18'h18000, 18'h00000, 1'b0, 6'h3D, 1'b1);
        do_left_justify_op(18'h3FFFE, 18'h00000, 1'b0, 18'h36124, 18'h20000, 18'h0FFFF, 1'b1, 6'h2C, 1'b0);
        do_left_justify_op(18'h00000, 18'h3FFFF, 1'b0, 18'h34103, 18'h00007, 18'h3FFF8, 1'b0, 6'h00, 1'b0);
        do_left_justify_op(18'h20000, 18'h00005, 1'b0, 18'h34105, 18'h20000, 18'h00005, 1'b0, 6'h3B, 1'b0);
    endtask

    // Full product, shortened step count, carry into the top bit; fetch answered at several speeds.
    task automatic t_multiply;
        do_mul(18'h00005, 1'b0, 18'h00002, 18'h35652, 18'h00000, 18'h0000A, 1'b0, 4'h0);
        do_mul(18'h00045, 1'b0, 18'h00003, 18'h35646, 18'h00000, 18'h0F001, 1'b0, 4'h3);
        do_mul(18'h3FFFF, 1'b0, 18'h3FFFF, 18'h35652, 18'h3FFFE, 18'h00001, 1'b0, 4'h1);
    endtask

    // Like signs, then unlike signs from either operand.
    task automatic t_signed_multiply;
        do_mul(18'h3FFFA, 1'b1, 18'h00002, 18'h35E52, 18'h00000, 18'h0000A, 1'b0, 4'h2);
        do_mul(18'h3FFFA, 1'b0, 18'h00002, 18'h35E52, 18'h30000, 18'h3FFF5, 1'b1, 4'h0);
        do_mul(18'h00005, 1'b1, 18'h00002, 18'h35E52, 18'h30000, 18'h3FFF5, 1'b1, 4'h5);
    endtask

    // Setup ops: sign to link, complement, move extension to sum, clear extension; no hold-off.
    task automatic t_setup;
        int hold;
        wr(nmu_pkg::OFF_SUM, 32'h0002ABCD);
        wr(nmu_pkg::OFF_EXT, 32'h00001234);
        wr(nmu_pkg::OFF_LINK, 32'h00000000);
        run_op(18'h36000, 1'b0, hold);
        rd_chk(nmu_pkg::OFF_LINK, 32'h00000001);
        run_op(18'h34004, 1'b0, hold);
        rd_chk(nmu_pkg::OFF_EXT, 32'h0003EDCB);
        run_op(18'h34202, 1'b0, hold);
        rd_chk(nmu_pkg::OFF_SUM, 32'h0003EDCB);
        run_op(18'h35000, 1'b0, hold);
        rd_chk(nmu_pkg::OFF_EXT, 32'h00000000);
        check(32'(hold), 32'h00000000);
    endtask

    // Reset for two cycles, then the scenarios in turn.
    initial begin
        rst_i     = 1'b1;
        wb_cyc    = 1'b0;
        wb_stb    = 1'b0;
        wb_we     = 1'b0;
        wb_adr    = 8'h00;
        wb_sel    = 4'h0;
        wb_wdat   = 32'h00000000;
        mem_word  = 18'h00000;
        mem_delay = 4'h0;
        fails     = 0;
        compares  = 0;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_setup();
        t_normalize();
        t_multiply();
        t_signed_multiply();
        final_report();
    end
endmodule // nmu_unit_tb
